// ===== hw/drt_pkg.sv
// constants and helpers shared by the debug discovery table block
`default_nettype none
package drt_pkg;

  // debug bus address width: one 4 KB table frame
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // byte offsets of the table words
  localparam logic [ADDR_W-1:0] PERF_MONITOR_POINTER_OFF   = 12'h000;
  localparam logic [ADDR_W-1:0] LOGIC_ANALYSER_POINTER_OFF = 12'h004;
  localparam logic [ADDR_W-1:0] CORE0_TABLE_POINTER_OFF    = 12'h008;
  localparam logic [ADDR_W-1:0] CORE1_TABLE_POINTER_OFF    = 12'h00C;
  localparam logic [ADDR_W-1:0] CORE2_TABLE_POINTER_OFF    = 12'h010;

  localparam int unsigned NUM_ENTRIES = 5;
  localparam int unsigned ENTRY_IDX_W = 3;
  localparam int unsigned NUM_CORE_ENTRIES = 3;
  localparam logic [ADDR_W-3:0] ENTRY_LIMIT = 10'h005;

  // field positions inside a table word
  localparam int unsigned OFFSET_LSB = 12;
  localparam int unsigned OFFSET_W   = 20;
  localparam int unsigned PDID_LSB   = 4;
  localparam int unsigned PDID_W     = 5;
  localparam int unsigned VALID_BIT  = 2;
  localparam int unsigned PRES_LSB   = 0;
  localparam int unsigned PRES_W     = 2;
  localparam int unsigned COMPONENT_SHIFT = 12;

  // component offsets, in 4 KB units from the table base
  localparam logic [OFFSET_W-1:0] PERF_OFFSET = 20'h00010;
  localparam logic [OFFSET_W-1:0] LA_OFFSET   = 20'h00020;
  localparam logic [OFFSET_W-1:0] CORE_OFFSET [NUM_CORE_ENTRIES] =
    '{20'h00070, 20'h000F0, 20'h00170};

  // presence codes
  localparam logic [PRES_W-1:0] PRES_LAST    = 2'h0;
  localparam logic [PRES_W-1:0] PRES_RSVD    = 2'h1;
  localparam logic [PRES_W-1:0] PRES_ABSENT  = 2'h2;
  localparam logic [PRES_W-1:0] PRES_PRESENT = 2'h3;

  // highest core-complex domain number
  localparam logic [PDID_W-1:0] PDID_MAX = 5'h0D;

  // bus output reset values
  localparam logic [DATA_W-1:0] PRDATA_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [OFFSET_W-1:0] offset;
    logic [PDID_W-1:0]   power_domain_number;
    logic                power_domain_number_valid;
    logic [PRES_W-1:0]   present;
  } drt_entry_t;

  // true when the byte address selects one of the table words
  function automatic logic drt_entry_hit(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && (a[ADDR_W-1:2] < ENTRY_LIMIT);
  endfunction

endpackage
`default_nettype wire

// ===== hw/drt_entry_pack.sv
// packs one table word from its fields, reserved bits forced low
`timescale 1ns/1ns
`default_nettype none
module drt_entry_pack
  import drt_pkg::*;
(
  input  wire logic [OFFSET_W-1:0] offset,
  input  wire logic [PDID_W-1:0]   power_domain_number,
  input  wire logic                power_domain_number_valid,
  input  wire logic [PRES_W-1:0]   present,
  input  wire logic                enable,
  output logic      [DATA_W-1:0]   word
);

  always_comb begin
    word = '0;
    // an entry that is not configured reads as all zero
    if (enable) begin
      word[OFFSET_LSB +: OFFSET_W] = offset;
      word[PDID_LSB +: PDID_W]     = power_domain_number;
      word[VALID_BIT]              = power_domain_number_valid;
      word[PRES_LSB +: PRES_W]     = present;
    end
  end

endmodule
`default_nettype wire

// ===== hw/drt_addr_decode.sv
// turns a debug bus byte address into a table index and a hit flag
`timescale 1ns/1ns
`default_nettype none
module drt_addr_decode
  import drt_pkg::*;
(
  input  wire logic [ADDR_W-1:0]      addr,
  output logic      [ENTRY_IDX_W-1:0] index,
  output logic                        hit
);

  // unaligned or out-of-range addresses miss and read as zero
  assign hit   = drt_entry_hit(addr);
  assign index = addr[2 +: ENTRY_IDX_W];

endmodule
`default_nettype wire

// ===== hw/drt_table_entries.sv
// debug discovery table: first five component pointer words on debug APB
`timescale 1ns/1ns
`default_nettype none
module drt_table_entries
  import drt_pkg::*;
#(
  parameter int unsigned                  CORE_COUNT    = 3,
  parameter logic                         LA_BUILT      = 1'b1,
  parameter logic [NUM_CORE_ENTRIES-1:0]  CORE_PD_VALID = 3'h7,
  parameter logic [NUM_CORE_ENTRIES*PDID_W-1:0] CORE_PD_NUM =
    {5'h02, 5'h01, 5'h00}
) (
  input  wire logic              CLOCK,
  input  wire logic              RST,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [DATA_W-1:0] PWDATA,
  output logic      [DATA_W-1:0] PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR
);

  // build-time field values of entry i
  function automatic drt_entry_t entry_fields(input int unsigned i);
    drt_entry_t f;
    f = '0;
    if (i == 0) begin
      f.offset  = PERF_OFFSET;
      f.present = PRES_PRESENT;
    end else if (i == 1) begin
      f.offset  = LA_OFFSET;
      f.present = LA_BUILT ? PRES_PRESENT : PRES_ABSENT;
    end else begin
      f.offset = CORE_OFFSET[i-2];
      f.power_domain_number       = CORE_PD_NUM[(i-2)*PDID_W +: PDID_W];
      f.power_domain_number_valid = CORE_PD_VALID[i-2];
      f.present = PRES_PRESENT;
    end
    return f;
  endfunction

  // whether entry i exists in this build
  function automatic logic entry_enabled(input int unsigned i);
    // core entries exist only for built cores
    return (i < 2) || ((i - 2) < CORE_COUNT);
  endfunction

  logic [DATA_W-1:0]      entry_word [NUM_ENTRIES];
  logic [ENTRY_IDX_W-1:0] read_index;
  logic                   read_hit;
  logic                   setup_phase;
  logic [DATA_W-1:0]      prdata_reg;
  logic [DATA_W-1:0]      prdata_next;
  logic                   pready_reg;
  logic                   pslverr_reg;

  for (genvar g = 0; g < NUM_ENTRIES; g++) begin : g_entry
    localparam drt_entry_t F = entry_fields(g);
    localparam logic       E = entry_enabled(g);
    drt_entry_pack u_pack (
      .offset                    (F.offset),
      .power_domain_number       (F.power_domain_number),
      .power_domain_number_valid (F.power_domain_number_valid),
      .present                   (F.present),
      .enable                    (E),
      .word                      (entry_word[g])
    );
  end

  drt_addr_decode u_decode (
    .addr  (PADDR),
    .index (read_index),
    .hit   (read_hit)
  );

  // the word is captured in the setup cycle so the access cycle
  // can answer from a flop with no wait state
  assign setup_phase = PSEL && !PENABLE;

  always_comb begin
    prdata_next = '0;
    // only a bus read reaches the table
    if (setup_phase && !PWRITE && read_hit) begin
      prdata_next = entry_word[read_index];
    end
  end

  // read-only data path; writes reach no storage
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      prdata_reg <= PRDATA_RESET;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= setup_phase;
    end
  end

  // unmapped reads and all writes complete without error
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= 1'b0;
    end
  end

  assign PRDATA  = prdata_reg;
  assign PREADY  = pready_reg;
  assign PSLVERR = pslverr_reg;

  // checks on the driven bus answers
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  localparam logic [DATA_W-1:0] EXP_ENTRY0 =
    {PERF_OFFSET, 9'h000, 1'b0, PRES_PRESENT};

  property p_ready_after_setup;
    PSEL && !PENABLE |=> PREADY ##1 !PREADY;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("ready did not follow setup for one cycle");

  property p_no_ready_idle;
    !PSEL |=> !PREADY;
  endproperty
  a_no_ready_idle: assert property (p_no_ready_idle)
    else $error("ready raised without a setup cycle");

  property p_entry0_word;
    setup_phase && !PWRITE && PADDR == PERF_MONITOR_POINTER_OFF
      |=> PREADY && PRDATA == EXP_ENTRY0;
  endproperty
  a_entry0_word: assert property (p_entry0_word)
    else $error("entry zero word wrong");

  property p_entry1_word;
    setup_phase && !PWRITE && PADDR == LOGIC_ANALYSER_POINTER_OFF
      |=> PRDATA[OFFSET_LSB +: OFFSET_W] == LA_OFFSET
        && PRDATA[VALID_BIT] == 1'b0
        && PRDATA[PRES_LSB +: PRES_W] ==
           (LA_BUILT ? PRES_PRESENT : PRES_ABSENT);
  endproperty
  a_entry1_word: assert property (p_entry1_word)
    else $error("entry one word wrong");

  property p_entry2_word;
    setup_phase && !PWRITE && PADDR == CORE0_TABLE_POINTER_OFF
      |=> PRDATA[OFFSET_LSB +: OFFSET_W] == CORE_OFFSET[0]
        && PRDATA[PDID_LSB +: PDID_W] == CORE_PD_NUM[0 +: PDID_W]
        && PRDATA[VALID_BIT] == CORE_PD_VALID[0]
        && PRDATA[PRES_LSB +: PRES_W] == PRES_PRESENT;
  endproperty
  a_entry2_word: assert property (p_entry2_word)
    else $error("entry two word wrong");

  property p_entry3_word;
    setup_phase && !PWRITE && PADDR == CORE1_TABLE_POINTER_OFF
      |=> (CORE_COUNT >= 2)
          ? (PRDATA[OFFSET_LSB +: OFFSET_W] == CORE_OFFSET[1]
             && PRDATA[PRES_LSB +: PRES_W] == PRES_PRESENT)
          : (PRDATA == '0);
  endproperty
  a_entry3_word: assert property (p_entry3_word)
    else $error("entry three word wrong for core count");

  property p_entry4_word;
    setup_phase && !PWRITE && PADDR == CORE2_TABLE_POINTER_OFF
      |=> (CORE_COUNT >= 3)
          ? (PRDATA[OFFSET_LSB +: OFFSET_W] == CORE_OFFSET[2]
             && PRDATA[PRES_LSB +: PRES_W] == PRES_PRESENT)
          : (PRDATA == '0);
  endproperty
  a_entry4_word: assert property (p_entry4_word)
    else $error("entry four word wrong for core count");

  property p_reserved_zero;
    PREADY |-> PRDATA[11:9] == 3'h0 && PRDATA[3] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits not zero");

  property p_shared_no_domain;
    setup_phase && !PWRITE && PADDR[ADDR_W-1:3] == '0 && PADDR[1:0] == 2'h0
      |=> PRDATA[VALID_BIT] == 1'b0 && PRDATA[8:4] == 5'h00;
  endproperty
  a_shared_no_domain: assert property (p_shared_no_domain)
    else $error("shared entry reports a domain number");

  property p_domain_range;
    PREADY && PRDATA[VALID_BIT] |-> PRDATA[PDID_LSB +: PDID_W] <= PDID_MAX;
  endproperty
  a_domain_range: assert property (p_domain_range)
    else $error("domain number above thirteen");

  property p_presence_legal;
    PREADY |-> PRDATA[PRES_LSB +: PRES_W] != PRES_RSVD;
  endproperty
  a_presence_legal: assert property (p_presence_legal)
    else $error("reserved presence code returned");

  property p_unmapped_zero;
    setup_phase && !drt_entry_hit(PADDR) |=> PRDATA == '0 && !PSLVERR;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped address did not read zero");

  property p_write_ignored;
    setup_phase && PWRITE && PADDR == PERF_MONITOR_POINTER_OFF
      ##1 1'b1 ##1 setup_phase && !PWRITE
        && PADDR == PERF_MONITOR_POINTER_OFF
      |=> PRDATA == EXP_ENTRY0;
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("write changed a table word");

  property p_write_reads_zero;
    setup_phase && PWRITE |=> PRDATA == '0 && !PSLVERR;
  endproperty
  a_write_reads_zero: assert property (p_write_reads_zero)
    else $error("write answered with data or error");

  property p_data_only_in_access;
    !PREADY |-> PRDATA == '0;
  endproperty
  a_data_only_in_access: assert property (p_data_only_in_access)
    else $error("read data outside access cycle");

  property p_ready_needs_setup;
    PREADY |-> $past(PSEL) && !$past(PENABLE);
  endproperty
  a_ready_needs_setup: assert property (p_ready_needs_setup)
    else $error("ready without setup in the cycle before");

  property p_no_error;
    PREADY |-> !PSLVERR;
  endproperty
  a_no_error: assert property (p_no_error)
    else $error("error response on a table access");

  property p_entry3_domain;
    setup_phase && !PWRITE && PADDR == CORE1_TABLE_POINTER_OFF
      && CORE_COUNT >= 2
      |=> PRDATA[PDID_LSB +: PDID_W] == CORE_PD_NUM[PDID_W +: PDID_W]
        && PRDATA[VALID_BIT] == CORE_PD_VALID[1];
  endproperty
  a_entry3_domain: assert property (p_entry3_domain)
    else $error("entry three domain fields wrong");

  property p_entry4_domain;
    setup_phase && !PWRITE && PADDR == CORE2_TABLE_POINTER_OFF
      && CORE_COUNT >= 3
      |=> PRDATA[PDID_LSB +: PDID_W] == CORE_PD_NUM[2*PDID_W +: PDID_W]
        && PRDATA[VALID_BIT] == CORE_PD_VALID[2];
  endproperty
  a_entry4_domain: assert property (p_entry4_domain)
    else $error("entry four domain fields wrong");

  property p_present_has_offset;
    PREADY && PRDATA[PRES_LSB +: PRES_W] == PRES_PRESENT
      |-> PRDATA[OFFSET_LSB +: OFFSET_W] != '0;
  endproperty
  a_present_has_offset: assert property (p_present_has_offset)
    else $error("present entry with zero offset");

  property p_last_entry_zero;
    PREADY && PRDATA[PRES_LSB +: PRES_W] == PRES_LAST |-> PRDATA == '0;
  endproperty
  a_last_entry_zero: assert property (p_last_entry_zero)
    else $error("absent last entry has nonzero fields");

endmodule
`default_nettype wire

// ===== verification/drt_apb_debugger.sv
// debug agent model: runs debug bus transfers and decodes pointer words
`timescale 1ns/1ns
`default_nettype none
module drt_apb_debugger #(
  parameter logic [31:0] TABLE_BASE = 32'h0001_0000
) (
  input  wire logic        CLOCK,
  input  wire logic        PREADY,
  input  wire logic [31:0] PRDATA,
  input  wire logic        PSLVERR,
  output logic             PSEL,
  output logic             PENABLE,
  output logic             PWRITE,
  output logic      [11:0] PADDR,
  output logic      [31:0] PWDATA
);
  initial begin
    PSEL = 1'h0;
    PENABLE = 1'h0;
    PWRITE = 1'h0;
    PADDR = 12'h000;
    PWDATA = 32'h0000_0000;
  end

  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err, output logic [31:0] comp,
                      output logic ok);
    int n;
    PSEL = 1'h1;
    PENABLE = 1'h0;
    PWRITE = wr;
    PADDR = a;
    PWDATA = wd;
    @(posedge CLOCK);
    #1 PENABLE = 1'h1;
    ok = 1'h0;
    for (n = 0; n < 4 && !ok; n++) begin
      @(posedge CLOCK);
      ok = (PREADY === 1'h1);
    end
    rd = PRDATA;
    err = PSLVERR;
    comp = TABLE_BASE + {PRDATA[31:12], 12'h000};
    #1;
  endtask

  // released lines flip so a stale value never looks valid
  task automatic idle();
    PSEL = 1'h0;
    PENABLE = 1'h0;
    PADDR = ~PADDR;
    PWDATA = ~PWDATA;
  endtask
endmodule
`default_nettype wire

// ===== verification/drt_table_entries_tb.sv
// self-checking bench for the debug discovery table
`timescale 1ns/1ns
`default_nettype none
module drt_table_entries_tb;
  import drt_pkg::*;
  localparam int unsigned TIMEOUT_CYCLES = 2000;
  localparam logic [2:0]  PD_VALID = 3'h5;
  localparam logic [14:0] PD_NUM   = {5'h0D, 5'h07, 5'h00};
  logic              clock   = 1'h0;
  logic              rst     = 1'h1;
  logic              sel_min = 1'h0;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata_a;
  logic [DATA_W-1:0] prdata_b;
  logic              pready_a;
  logic              pready_b;
  logic              pslverr_a;
  logic              pslverr_b;
  int                miscompares = 0;
  int                n_tests = 0;
  int                cycles = 0;

  always #5 clock = ~clock;

  drt_table_entries #(.CORE_COUNT(3), .LA_BUILT(1'h1),
    .CORE_PD_VALID(PD_VALID), .CORE_PD_NUM(PD_NUM)) uut (
    .CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata_a),
    .PREADY(pready_a), .PSLVERR(pslverr_a));
  // smallest build: one core, no analyser
  drt_table_entries #(.CORE_COUNT(1), .LA_BUILT(1'h0),
    .CORE_PD_VALID(PD_VALID), .CORE_PD_NUM(PD_NUM)) uut_min (
    .CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata_b),
    .PREADY(pready_b), .PSLVERR(pslverr_b));
  drt_apb_debugger dbg (
    .CLOCK(clock), .PREADY(sel_min ? pready_b : pready_a),
    .PRDATA(sel_min ? prdata_b : prdata_a),
    .PSLVERR(sel_min ? pslverr_b : pslverr_a), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata));

  task automatic end_sim();
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles >= TIMEOUT_CYCLES) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic check32(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask

  task automatic check1(string what, logic exp, logic got);
    n_tests++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
      miscompares++;
    end
  endtask

  function automatic logic [31:0] core_word(int n, int count);
    if (n >= count) return 32'h0000_0000;
    return {CORE_OFFSET[n], 3'h0, PD_NUM[5*n +: 5], 1'h0, PD_VALID[n], 2'h3};
  endfunction

  function automatic logic [31:0] exp_main(logic [11:0] a);
    if (a[1:0] != 2'h0 || a >= 12'h014) return 32'h0000_0000;
    if (a == 12'h000) return 32'h0001_0003;
    if (a == 12'h004) return 32'h0002_0003;
    return core_word(int'(a[4:2]) - 2, 3);
  endfunction

  task automatic acc(input logic wr, input logic [11:0] a,
                     output logic [31:0] d, output logic [31:0] c);
    logic err;
    logic ok;
    dbg.xfer(wr, a, 32'hFFFF_FFFF, d, err, c, ok);
    check1("ready", 1'h1, ok);
    check1("error flag", 1'h0, err);
  endtask

  task automatic t_main_table();
    logic [31:0] d [5];
    logic [31:0] c [5];
    int i;
    for (i = 0; i < 5; i++)
      acc(1'h0, 12'(4 * i), d[i], c[i]);
    dbg.idle();
    check32("entry0", 32'h0001_0003, d[0]);
    check32("entry1", 32'h0002_0003, d[1]);
    check32("entry2", core_word(0, 3), d[2]);
    check32("entry3", core_word(1, 3), d[3]);
    check32("entry4", core_word(2, 3), d[4]);
    check32("monitor addr", 32'h0002_0000, c[0]);
    check32("analyser addr", 32'h0003_0000, c[1]);
    check32("core0 addr", 32'h0008_0000, c[2]);
    check32("core1 addr", 32'h0010_0000, c[3]);
    check32("core2 addr", 32'h0018_0000, c[4]);
    @(posedge clock);
    #1 check1("ready idle", 1'h0, pready_a);
  endtask

  task automatic t_min_table();
    logic [31:0] d [5];
    logic [31:0] c;
    int i;
    sel_min = 1'h1;
    for (i = 1; i < 5; i++)
      acc(1'h0, 12'(4 * i), d[i], c);
    dbg.idle();
    check32("min entry1", 32'h0002_0002, d[1]);
    check32("min entry2", core_word(0, 1), d[2]);
    check32("min entry3", 32'h0000_0000, d[3]);
    check32("min entry4", 32'h0000_0000, d[4]);
    @(posedge clock);
    #1 sel_min = 1'h0;
  endtask

  // every table word and some unmapped places, written then read back
  task automatic t_write_ignored();
    logic [11:0] addrs [9] = '{12'h000, 12'h004, 12'h008, 12'h00C,
                               12'h010, 12'h014, 12'h002, 12'h7FF, 12'hFFC};
    logic [31:0] d;
    logic [31:0] c;
    int i;
    for (i = 0; i < 9; i++) begin
      acc(1'h1, addrs[i], d, c);
      acc(1'h0, addrs[i], d, c);
      check32("read after write", exp_main(addrs[i]), d);
    end
    dbg.idle();
  endtask

  initial begin
    repeat (6) @(posedge clock);
    #1 rst = 1'h0;
    @(posedge clock);
    #1 check1("ready after reset", 1'h0, pready_a);
    check32("data after reset", 32'h0000_0000, prdata_a);
    t_main_table();
    t_min_table();
    t_write_ignored();
    end_sim();
  end
endmodule
`default_nettype wire
